// >>> verilog/scmr_pkg.sv
// Package for the serial configuration memory reader.
// Assumes a 100 MHz system clock and a separately clocked serial link.
package scmr_pkg;

    // ------------------------------------------------------------
    // Memory sizes
    // ------------------------------------------------------------
    localparam int MIN_DEPTH_BITS  = 65536;
    localparam int MAX_DEPTH_BITS  = 2097152;
    localparam int NUM_SIZES       = 6;
    localparam int MAX_ADDR_W      = 21;
    // Lowest block guarded by the write-protect pin on small sizes while chip select is low
    localparam int LOW_BLOCK_BITS  = 4096;
    // Large sizes start at this depth; the guard pin covers the top half
    localparam int LARGE_MIN_BITS  = 524288;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int POR_TIME_NS     = 2000;
    localparam int POR_CYCLES      =
        (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_HALF_NS     = 20;
    localparam int OSC_HALF_CYCLES =
        (OSC_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : OSC_HALF_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Reset values and fixed levels
    // ------------------------------------------------------------
    localparam logic RST_CASCADE_N = 1'b1;
    localparam logic RST_DATA      = 1'b0;
    localparam logic OPEN_DRAIN_LO = 1'b0;
    localparam logic POL_DEFAULT   = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  wr;
        logic [MAX_ADDR_W-1:0] addr;
        logic                  wdata;
    } scmr_prog_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } scmr_pin_drive_t;

    typedef enum logic [1:0] {
        SCMR_POR,
        SCMR_IDLE,
        SCMR_RUN,
        SCMR_PROG
    } scmr_mode_t;

endpackage : scmr_pkg

// >>> verilog/scmr_reader.sv
// Read side of a serial configuration memory with cascade hand-over.
// Assumes config_clock is the serial clock pin as seen at the device;
// when this device is chain master, it also drives that pin itself.
`timescale 1ns/1ps
`default_nettype none

module scmr_reader #(
    // Size index 0..5 selects 64Ki to 2Mi bits
    parameter int SIZE_SEL    = 0,
    parameter int POR_CYC     = scmr_pkg::POR_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     config_clock,
    input  wire logic                     config_clock_in,
    output var  logic                     config_clock_out,
    output var  logic                     config_clock_oe,
    input  wire logic                     reset_oe,
    input  wire logic                     reset_polarity_high,
    input  wire logic                     chip_select_n,
    output var  logic                     cascade_select_n,
    input  wire logic                     data_in,
    output var  logic                     data_out,
    output var  logic                     data_oe,
    input  wire logic                     write_guard_one,
    input  wire logic                     device_select_input,
    input  wire logic                     serial_program_enable_n,
    input  wire scmr_pkg::scmr_prog_req_t prog_req,
    output var  logic                     prog_rdata,
    output var  logic                     ready_out,
    output var  logic                     ready_oe,
    output var  logic                     master_role,
    output var  scmr_pkg::scmr_mode_t     mode
);
    import scmr_pkg::*;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    // counter just wide enough for the depth
    localparam int DEPTH  = MIN_DEPTH_BITS << SIZE_SEL;
    localparam int AW     = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST_ADDR  = AW'(DEPTH - 1);
    localparam logic [AW-1:0] LOW_BLK    = AW'(LOW_BLOCK_BITS);
    localparam logic [AW-1:0] HALF_ADDR  = AW'(DEPTH / 2);
    localparam bit    IS_LARGE = DEPTH >= LARGE_MIN_BITS;
    localparam int    PCW      = $clog2(POR_CYC + 1);
    localparam int    OCW      = $clog2(OSC_HALF_CYCLES + 1);

    // Bit store; written from clk, read from the link clock
    logic mem [DEPTH];

    // Link-side state that the system side also watches
    logic link_done;
    logic data_q;

    // ------------------------------------------------------------
    // System domain: pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] s_rst_pin;
    logic [1:0] s_pol;
    logic [1:0] s_cs_n;
    logic [1:0] s_ser_n;
    logic [1:0] s_dsel;
    logic [1:0] s_guard;
    logic [1:0] s_done;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_rst_pin <= 2'h0;
            s_pol     <= 2'h0;
            s_cs_n    <= 2'h3;
            s_ser_n   <= 2'h3;
            s_dsel    <= 2'h0;
            s_guard   <= 2'h0;
            s_done    <= 2'h0;
        end else begin
            s_rst_pin <= {s_rst_pin[0], reset_oe};
            s_pol     <= {s_pol[0], reset_polarity_high};
            s_cs_n    <= {s_cs_n[0], chip_select_n};
            s_ser_n   <= {s_ser_n[0], serial_program_enable_n};
            s_dsel    <= {s_dsel[0], device_select_input};
            s_guard   <= {s_guard[0], write_guard_one};
            s_done    <= {s_done[0], link_done};
        end
    end

    // polarity: default low level means reset
    logic sys_in_reset;
    logic sys_prog_mode;
    assign sys_in_reset  = (s_rst_pin[1] == s_pol[1]);
    assign sys_prog_mode = !s_ser_n[1] && s_dsel[1];

    // ------------------------------------------------------------
    // Power-on sequencing and ready pin
    // ------------------------------------------------------------
    logic [PCW-1:0] por_cnt;
    logic           por_busy;

    // ready pulled low until power-up completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt  <= '0;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            if (por_cnt == PCW'(POR_CYC - 1)) begin
                por_busy <= 1'b0;
            end
            por_cnt <= por_cnt + PCW'(1);
        end
    end

    assign ready_out = OPEN_DRAIN_LO;
    assign ready_oe  = por_busy;

    // ------------------------------------------------------------
    // Chain role
    // ------------------------------------------------------------
    logic sys_in_reset_d;

    // chip select sampled as reset releases
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_in_reset_d <= 1'b1;
            master_role    <= 1'b0;
        end else begin
            sys_in_reset_d <= sys_in_reset || por_busy;
            if (sys_in_reset_d && !sys_in_reset && !por_busy) begin
                master_role <= !s_cs_n[1];
            end
        end
    end

    // ------------------------------------------------------------
    // Mode tracking
    // ------------------------------------------------------------
    scmr_mode_t next_mode;

    always_comb begin
        next_mode = mode;
        case (mode)
            SCMR_POR: begin
                if (!por_busy) begin
                    next_mode = SCMR_IDLE;
                end
            end
            SCMR_IDLE, SCMR_RUN: begin
                if (sys_prog_mode) begin
                    next_mode = SCMR_PROG;
                end else if (!sys_in_reset && !s_cs_n[1] && !s_done[1]) begin
                    next_mode = SCMR_RUN;
                end else begin
                    next_mode = SCMR_IDLE;
                end
            end
            SCMR_PROG: begin
                if (!sys_prog_mode) begin
                    next_mode = SCMR_IDLE;
                end
            end
            default: next_mode = SCMR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= SCMR_POR;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------
    logic [OCW-1:0] osc_cnt;
    logic           osc_run;
    // clock runs only in run mode and only for the chain master
    assign osc_run = (mode == SCMR_RUN) && master_role;

    // oscillator halted and pin low in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt          <= '0;
            config_clock_out <= 1'b0;
        end else if (!osc_run) begin
            osc_cnt          <= '0;
            config_clock_out <= 1'b0;
        end else if (osc_cnt == OCW'(OSC_HALF_CYCLES - 1)) begin
            osc_cnt          <= '0;
            config_clock_out <= !config_clock_out;
        end else begin
            osc_cnt          <= osc_cnt + OCW'(1);
        end
    end

    // Only the chain master owns the clock pin; others just listen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_clock_oe <= 1'b0;
        end else begin
            config_clock_oe <= master_role && !sys_prog_mode;
        end
    end

    // ------------------------------------------------------------
    // Programming writes and readback
    // ------------------------------------------------------------
    logic [AW-1:0] p_addr;
    logic          guard_hit;
    assign p_addr = prog_req.addr[AW-1:0];

    generate
        if (IS_LARGE) begin : g_large_guard
            // guard pin protects the upper half when programming
            assign guard_hit = s_guard[1] && (p_addr >= HALF_ADDR);
        end else begin : g_small_guard
            // guard pin blocks the lowest block while chip select is low
            assign guard_hit = s_guard[1] && !s_cs_n[1] && (p_addr < LOW_BLK);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (mode == SCMR_PROG && prog_req.wr && !guard_hit) begin
            mem[p_addr] <= prog_req.wdata;
        end
    end

    logic prog_oe;
    // open-drain during programming: pull low for a zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata <= RST_DATA;
            prog_oe    <= 1'b0;
        end else begin
            prog_rdata <= mem[p_addr];
            prog_oe    <= (mode == SCMR_PROG) && !prog_req.wr && !mem[p_addr];
        end
    end

    // ------------------------------------------------------------
    // Link domain: pin synchronisers on the serial clock
    // ------------------------------------------------------------
    logic [1:0] l_rst_pin;
    logic [1:0] l_pol;
    logic [1:0] l_cs_n;
    logic [1:0] l_ser_n;

    always_ff @(posedge config_clock or negedge rst_n) begin
        if (!rst_n) begin
            l_rst_pin <= 2'h0;
            l_pol     <= 2'h0;
            l_cs_n    <= 2'h3;
            l_ser_n   <= 2'h3;
        end else begin
            l_rst_pin <= {l_rst_pin[0], reset_oe};
            l_pol     <= {l_pol[0], reset_polarity_high};
            l_cs_n    <= {l_cs_n[0], chip_select_n};
            l_ser_n   <= {l_ser_n[0], serial_program_enable_n};
        end
    end

    logic link_reset;
    logic link_en;
    logic [AW-1:0] addr;

    // same polarity decode as the system side
    assign link_reset = (l_rst_pin[1] == l_pol[1]);
    // count only when enabled, selected and data remains
    // loading assumes serial enable stays high
    assign link_en = !link_reset && !l_cs_n[1] && !link_done && l_ser_n[1];

    // ------------------------------------------------------------
    // Address counter and serial data
    // ------------------------------------------------------------
    // power-up clears the counter via rst_n
    // reset level clears the counter regardless of select
    // each rising edge presents a bit and advances
    // counter parks at the final address
    always_ff @(posedge config_clock or negedge rst_n) begin
        if (!rst_n) begin
            addr      <= '0;
            link_done <= 1'b0;
            data_q    <= RST_DATA;
        end else if (link_reset) begin
            addr      <= '0;
            link_done <= 1'b0;
        end else if (link_en) begin
            data_q <= mem[addr];
            if (addr == LAST_ADDR) begin
                link_done <= 1'b1;
            end else begin
                addr <= addr + AW'(1);
            end
        end
    end

    logic link_oe;

    // cascade goes low once the final bit is out
    // on the next clock after the last bit
    always_ff @(posedge config_clock or negedge rst_n) begin
        if (!rst_n) begin
            cascade_select_n <= RST_CASCADE_N;
        end else if (link_reset) begin
            cascade_select_n <= RST_CASCADE_N;
        end else if (link_done && !l_cs_n[1]) begin
            cascade_select_n <= 1'b0;
        end
    end

    // chip select high keeps the driver off
    // chip select low with output enabled turns it on
    // driver off once cascade has handed over
    // standby floats the pin whatever the reset pin says
    always_ff @(posedge config_clock or negedge rst_n) begin
        if (!rst_n) begin
            link_oe <= 1'b0;
        end else begin
            link_oe <= !link_reset && !l_cs_n[1] && l_ser_n[1]
                       && !(link_done && !l_cs_n[1]) && cascade_select_n;
        end
    end

    // ------------------------------------------------------------
    // Data pin
    // ------------------------------------------------------------
    // three-state for readout, open-drain for programming
    // data_in is never observed; programming data arrives through the bit port
    assign data_out = (mode == SCMR_PROG) ? OPEN_DRAIN_LO : data_q;
    assign data_oe  = (mode == SCMR_PROG) ? prog_oe : link_oe;

endmodule : scmr_reader

`default_nettype wire

// >>> dv/scmr_reader_asserts.sv
// Port checker for the configuration memory reader.
// Assumes it is bound into scmr_reader; the bind follows the module.
`timescale 1ns/1ps
`default_nettype none
module scmr_reader_chk #(
    parameter int POR_CYC = 10
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 config_clock,
    input wire logic                 config_clock_out,
    input wire logic                 config_clock_oe,
    input wire logic                 reset_oe,
    input wire logic                 reset_polarity_high,
    input wire logic                 chip_select_n,
    input wire logic                 cascade_select_n,
    input wire logic                 data_out,
    input wire logic                 data_oe,
    input wire logic                 device_select_input,
    input wire logic                 serial_program_enable_n,
    input wire logic                 ready_oe,
    input wire logic                 master_role,
    input wire scmr_pkg::scmr_mode_t mode
);
    import scmr_pkg::*;
    localparam int POR_LO = POR_CYC - 3;
    localparam int POR_HI = POR_CYC + 2;
    logic rst_lvl;
    assign rst_lvl = (reset_oe == reset_polarity_high);

    // ----------------------------------------------------------
    // Link side
    // ----------------------------------------------------------
    // Pin levels pass a two-edge synchroniser, hence the repeats
    sequence s_rst_held;
        rst_lvl [*3];
    endsequence
    sequence s_idle;
        (chip_select_n && serial_program_enable_n && !rst_lvl) [*3];
    endsequence

    a_reset_float: assert property (
        @(posedge config_clock) disable iff (!rst_n)
        s_rst_held |=> !data_oe)
        else $error("data driven while held at reset level");
    a_standby_float: assert property (
        @(posedge config_clock) disable iff (!rst_n)
        (chip_select_n && serial_program_enable_n) [*3] |=> !data_oe)
        else $error("data driven in standby");
    a_cascade_float: assert property (
        @(posedge config_clock) disable iff (!rst_n)
        (!cascade_select_n) [*2] |=> !data_oe)
        else $error("data driven after cascade hand-over");
    a_idle_stable: assert property (
        @(posedge config_clock) disable iff (!rst_n)
        s_idle |=> $stable(data_out))
        else $error("data moved while not selected");

    // ----------------------------------------------------------
    // System side
    // ----------------------------------------------------------
    a_ready_release: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> ready_oe ##[POR_LO:POR_HI] !ready_oe)
        else $error("ready release out of window");
    a_prog_enter: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!serial_program_enable_n && device_select_input && !ready_oe)
        [*4] |-> mode == SCMR_PROG)
        else $error("programming mode not entered");
    a_prog_leave: assert property (
        @(posedge clk) disable iff (!rst_n)
        serial_program_enable_n [*4] |-> mode != SCMR_PROG)
        else $error("programming mode while serial enable high");
    a_master_clk_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        (config_clock_oe && rst_lvl) [*6] |=> !config_clock_out)
        else $error("master clock runs in reset");
    a_slave_no_drive: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!master_role) [*2] |-> !config_clock_oe)
        else $error("clock pin driven by a follower");
endmodule : scmr_reader_chk

bind scmr_reader scmr_reader_chk #(.POR_CYC(POR_CYC)) scmr_reader_chk_inst (
    .clk, .rst_n, .config_clock, .config_clock_out, .config_clock_oe,
    .reset_oe, .reset_polarity_high, .chip_select_n, .cascade_select_n,
    .data_out, .data_oe, .device_select_input, .serial_program_enable_n,
    .ready_oe, .master_role, .mode
);
`default_nettype wire

// >>> dv/scmr_fpga_model.sv
// Far-side model: the loading device's serial clock and data input.
// Assumes the bench resolves the clock and data pins around it.
`timescale 1ns/1ps
`default_nettype none
module scmr_fpga_model (
    output var logic link_clk,
    input  wire logic data_pin
);
    logic [63:0] cap;
    initial begin
        link_clk = 1'b0;
        cap = '0;
    end

    // ----------------------------------------------------------
    // Frame of clock pulses; clock stands low between frames
    // ----------------------------------------------------------
    // bit taken at each fall
    task automatic frame(input int n);
        cap = '0;
        #3;
        for (int k = 0; k < n; k++) begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
            cap[k] = data_pin;
        end
    endtask : frame
endmodule : scmr_fpga_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the configuration memory reader.
// Assumes the far-side model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scmr_pkg::*;
    localparam logic [15:0] PAT = 16'hB38D;
    localparam int POR_SIM = 10;
    logic clk, rst_n, reset_oe, reset_polarity_high, chip_select_n;
    logic write_guard_one, device_select_input, serial_program_enable_n;
    scmr_prog_req_t prog_req;
    logic config_clock_out, config_clock_oe, cascade_select_n, data_out;
    logic data_oe, prog_rdata, ready_out, ready_oe, master_role;
    scmr_mode_t mode;
    logic link_clk, clk_pin, data_pin, ready_pin;
    int n_mismatch, n_compared;

    // Pull-ups on data and ready; clock pin follows the far-side model when the reader does not drive it
    assign clk_pin = config_clock_oe ? config_clock_out : link_clk;
    assign data_pin = data_oe ? data_out : 1'b1;
    assign ready_pin = ready_oe ? ready_out : 1'b1;

    scmr_reader #(.POR_CYC(POR_SIM)) scmr_reader_inst (
        .clk, .rst_n, .config_clock(clk_pin), .config_clock_in(clk_pin),
        .config_clock_out, .config_clock_oe, .reset_oe,
        .reset_polarity_high, .chip_select_n, .cascade_select_n,
        .data_in(data_pin), .data_out, .data_oe, .write_guard_one,
        .device_select_input, .serial_program_enable_n, .prog_req,
        .prog_rdata, .ready_out, .ready_oe, .master_role, .mode
    );
    scmr_fpga_model scmr_fpga_model_inst (.link_clk, .data_pin);

    always #5 clk = ~clk;

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic wr(input int a, input logic b);
        @(posedge clk) prog_req <= '{1'b1, a[MAX_ADDR_W-1:0], b};
    endtask : wr
    task automatic rd(input int a, input logic e);
        @(posedge clk) prog_req <= '{1'b0, a[MAX_ADDR_W-1:0], 1'b0};
        repeat (3) @(posedge clk);
        #1;
        check(prog_rdata, e);
        check(data_pin, e);
    endtask : rd
    task automatic stream();
        scmr_fpga_model_inst.frame(14);
        for (int k = 3; k < 14; k++)
            check(scmr_fpga_model_inst.cap[k], PAT[k-2]);
        check(cascade_select_n, 1);
    endtask : stream
    task automatic power_up();
        fork
            scmr_fpga_model_inst.frame(1);
            repeat (5) @(posedge clk);
        join
        #1 check(ready_pin, 0);
        check(mode, SCMR_POR);
        @(posedge clk) rst_n <= 1'b1;
        for (int i = 0; i < 60 && ready_oe !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        #1 check(ready_pin, 1);
    endtask : power_up

    // ----------------------------------------------------------
    // Tests
    // ----------------------------------------------------------
    initial begin
        clk = 0; rst_n = 0; reset_oe = 1; reset_polarity_high = 0;
        chip_select_n = 1; write_guard_one = 0; device_select_input = 0;
        serial_program_enable_n = 1; prog_req = '0;
        n_mismatch = 0; n_compared = 0;
        power_up();
        check(master_role, 0);
        check(config_clock_oe, 0);
        @(posedge clk) serial_program_enable_n <= 1'b0;
        device_select_input <= 1'b1;
        chip_select_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(mode, SCMR_PROG);
        for (int i = 0; i < 16; i++) wr(i, PAT[i]);
        @(posedge clk) prog_req <= '0;
        write_guard_one <= 1'b1;
        // Guard pin needs its two synchroniser edges before it bites
        repeat (2) @(posedge clk);
        wr(0, !PAT[0]);
        wr(4096, 1'b1);
        @(posedge clk) prog_req <= '0;
        rd(0, PAT[0]);
        rd(4096, 1'b1);
        rd(5, PAT[5]);
        // serial enable held high for loading
        @(posedge clk) serial_program_enable_n <= 1'b1;
        device_select_input <= 1'b0;
        write_guard_one <= 1'b0;
        repeat (4) @(posedge clk);
        stream();
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) chip_select_n <= 1'b1;
            reset_polarity_high <= p[0];
            reset_oe <= p[0];
            scmr_fpga_model_inst.frame(4);
            check(data_oe, 0);
            @(posedge clk) reset_oe <= !p[0];
            scmr_fpga_model_inst.frame(4);
            check(data_oe, 0);
            check(scmr_fpga_model_inst.cap[3:0], 4'hF);
            @(posedge clk) chip_select_n <= 1'b0;
            stream();
        end
        @(posedge clk) rst_n <= 1'b0;
        reset_polarity_high <= 1'b0;
        reset_oe <= 1'b1;
        power_up();
        @(posedge clk) #1 check(master_role, 1);
        @(posedge clk) #1 check(config_clock_oe, 1);
        @(posedge clk) reset_oe <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            #1 check(config_clock_out, 0);
        end
        @(posedge clk) reset_oe <= 1'b1;
        for (int i = 0; i < 40 && config_clock_out !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(config_clock_out, 1);
        finish_test();
    end

    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
